// File: src/ebrwc_top.sv
`default_nettype none

module ebrwc_top #(
    parameter int AW = 8,
    parameter int UNIT_DIV = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // axi4-lite write channels
    input wire logic [AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read channels
    input wire logic [AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // external bus
    output logic [ebrwc_pkg::BUS_AW-1:0] bus_addr_o,
    output logic bus_cs_n_o,
    output logic bus_rd_n_o,
    output logic bus_wr_n_o,
    output logic [ebrwc_pkg::BUS_DW-1:0] bus_data_o,
    output logic bus_data_oe_o,
    input wire logic [ebrwc_pkg::BUS_DW-1:0] bus_data_i,
    input wire logic bus_ready_i,
    output logic reference_clock_output_o
);
    import ebrwc_pkg::*;

    // address bits [7:2] are decoded, so narrower buses cannot be served
    if (AW < 8) begin : g_chk
        $error("ebrwc_top: AW must be at least 8");
    end

    typedef struct packed {
        ebrwc_phase_e st;
        logic [5:0] cnt;
        logic [7:0] waits;
        logic [7:0] last_waits;
        logic asy_done;
        logic is_wr;
        logic [BUS_AW-1:0] addr;
        logic [BUS_DW-1:0] wdat;
        logic [BUS_DW-1:0] rdat;
        logic [BUS_DW-1:0] d_s1;
        logic [BUS_DW-1:0] d_s2;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic d_oe;
        logic [CTRL_W-1:0] ctrl;
        logic [TIM_W-1:0] tim;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ebrwc_top_s;

    ebrwc_top_s r_reg;
    ebrwc_top_s r_next;
    logic tick;
    logic rdy_act;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    // phase counter preload: length in units minus one
    function automatic logic [5:0] ph_load(input ebrwc_phase_e ph, input logic [TIM_W-1:0] t);
        logic [5:0] v;
        v = 6'h00;
        case (ph)
            PH_AB: v = {5'h00, t[TIM_AB]};
            PH_C: v = {4'h0, t[TIM_C_LSB +: 2]} - 6'h01;
            PH_D: v = 6'h00;
            PH_E: v = {1'b0, t[TIM_E_LSB +: 5]};
            PH_F: v = {4'h0, t[TIM_F_LSB +: 2]} - 6'h01;
            default: v = 6'h00;
        endcase
        return v;
    endfunction : ph_load

    // zero-length phases are skipped
    function automatic ebrwc_phase_e ph_after(input ebrwc_phase_e ph, input logic [TIM_W-1:0] t);
        ebrwc_phase_e n;
        n = PH_IDLE;
        case (ph)
            PH_AB: n = (t[TIM_C_LSB +: 2] != 2'h0) ? PH_C : (t[TIM_D] ? PH_D : PH_E);
            PH_C: n = t[TIM_D] ? PH_D : PH_E;
            PH_D: n = PH_E;
            PH_E: n = (t[TIM_F_LSB +: 2] != 2'h0) ? PH_F : PH_IDLE;
            default: n = PH_IDLE;
        endcase
        return n;
    endfunction : ph_after

    function automatic logic [31:0] reg_read(input logic [7:0] a, input ebrwc_top_s s,
                                             input logic act);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_CTRL: v[CTRL_W-1:0] = s.ctrl;
            OFS_TIMING: v[TIM_W-1:0] = s.tim;
            OFS_CMD: begin
                v[BUS_AW-1:0] = s.addr;
                v[CMD_WRITE] = s.is_wr;
            end
            OFS_WDATA: v[BUS_DW-1:0] = s.wdat;
            OFS_STATUS: begin
                v[STAT_BUSY] = (s.st != PH_IDLE);
                v[STAT_RDY] = act;
                v[STAT_WAITS_LSB +: 8] = s.last_waits;
            end
            OFS_RDATA: v[BUS_DW-1:0] = s.rdat;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_read

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_TIMING) || (a == OFS_CMD) || (a == OFS_WDATA)
            || (a == OFS_STATUS) || (a == OFS_RDATA);
    endfunction : mapped

    // ****************************************
    // submodules
    // ****************************************
    ebrwc_unit_div #(
        .DIV(UNIT_DIV)
    ) u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick),
        .ref_clk_o(reference_clock_output_o)
    );

    ebrwc_rdy_sync u_rdy (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ready_pin_i(bus_ready_i),
        .pol_high_i(r_reg.ctrl[CTRL_RDY_POL]),
        .async_i(r_reg.ctrl[CTRL_ASYNC]),
        .rdy_active_o(rdy_act)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [7:0] wa;
        logic [31:0] wv;
        logic start;
        logic finish;
        wa = {r_reg.awaddr[7:2], 2'b00};
        wv = 32'h0000_0000;
        start = 1'b0;
        finish = 1'b0;
        r_next = r_reg;
        r_next.d_s1 = bus_data_i;
        r_next.d_s2 = r_reg.d_s1;

        // register writes; address and data accepted in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = 8'(s_axi_awaddr_i);
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            r_next.w_got = 1'b1;
            r_next.wdata = s_axi_wdata_i;
            r_next.wstrb = s_axi_wstrb_i;
        end
        if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            case (wa)
                OFS_CTRL: begin
                    wv = merge(32'(r_reg.ctrl), r_reg.wdata, r_reg.wstrb);
                    r_next.ctrl = wv[CTRL_W-1:0];
                end
                OFS_TIMING: begin
                    wv = merge(32'(r_reg.tim), r_reg.wdata, r_reg.wstrb);
                    r_next.tim = wv[TIM_W-1:0];
                end
                OFS_WDATA: begin
                    wv = merge(32'(r_reg.wdat), r_reg.wdata, r_reg.wstrb);
                    r_next.wdat = wv[BUS_DW-1:0];
                end
                OFS_CMD: begin
                    // a command while a cycle runs would corrupt it: refused
                    if (r_reg.st == PH_IDLE) begin
                        wv = merge(32'h0000_0000, r_reg.wdata, r_reg.wstrb);
                        start = 1'b1;
                    end else begin
                        r_next.bresp = RESP_SLVERR;
                    end
                end
                OFS_STATUS, OFS_RDATA: r_next.bresp = RESP_OKAY;
                default: r_next.bresp = RESP_SLVERR;
            endcase
        end
        if (r_reg.bvalid && s_axi_bready_i) begin
            r_next.bvalid = 1'b0;
        end

        // register reads
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = reg_read({s_axi_araddr_i[7:2], 2'b00}, r_reg, rdy_act);
            r_next.rresp = mapped({s_axi_araddr_i[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        end else if (r_reg.rvalid && s_axi_rready_i) begin
            r_next.rvalid = 1'b0;
        end

        // bus cycle sequencer
        if (start) begin
            r_next.addr = wv[BUS_AW-1:0];
            r_next.is_wr = wv[CMD_WRITE];
            r_next.st = PH_AB;
            r_next.cnt = ph_load(PH_AB, r_reg.tim);
            r_next.waits = 8'h00;
            r_next.asy_done = 1'b0;
        end else if (tick && r_reg.st != PH_IDLE) begin
            if (r_reg.cnt != 6'h00) begin
                // mandatory units still running, handshake not looked at
                r_next.cnt = r_reg.cnt - 6'h01;
            end else if (r_reg.st != PH_E) begin
                r_next.st = ph_after(r_reg.st, r_reg.tim);
                r_next.cnt = ph_load(r_next.st, r_reg.tim);
            end else if (!r_reg.ctrl[CTRL_RDY_EN]) begin
                finish = 1'b1;
            end else if (r_reg.ctrl[CTRL_ASYNC] && !r_reg.asy_done) begin
                // later sample point covers the extra stage
                r_next.asy_done = 1'b1;
                r_next.waits = (r_reg.waits == WAITS_MAX) ? WAITS_MAX : r_reg.waits + 8'h01;
            end else if (rdy_act) begin
                finish = 1'b1;
            end else begin
                r_next.waits = (r_reg.waits == WAITS_MAX) ? WAITS_MAX : r_reg.waits + 8'h01;
            end
        end
        if (finish) begin
            r_next.st = ph_after(PH_E, r_reg.tim);
            r_next.cnt = ph_load(r_next.st, r_reg.tim);
            r_next.last_waits = r_reg.waits;
            if (!r_reg.is_wr) begin
                r_next.rdat = r_reg.d_s2; // same edge as strobe release
            end
        end

        // pin levels follow the phase being entered
        r_next.cs_n = (r_next.st == PH_IDLE);
        r_next.rd_n = !(!r_next.is_wr && (r_next.st == PH_D || r_next.st == PH_E));
        r_next.wr_n = !(r_next.is_wr && r_next.st == PH_E);
        r_next.d_oe = r_next.is_wr && (r_next.st == PH_D || r_next.st == PH_E
            || r_next.st == PH_F);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
            r_reg.st <= PH_IDLE;
            r_reg.cs_n <= 1'b1;
            r_reg.rd_n <= 1'b1;
            r_reg.wr_n <= 1'b1;
            r_reg.ctrl <= CTRL_RST;
            r_reg.tim <= TIM_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready_o = !r_reg.aw_got && !r_reg.bvalid;
    assign s_axi_wready_o = !r_reg.w_got && !r_reg.bvalid;
    assign s_axi_bvalid_o = r_reg.bvalid;
    assign s_axi_bresp_o = r_reg.bresp;
    assign s_axi_arready_o = !r_reg.rvalid;
    assign s_axi_rvalid_o = r_reg.rvalid;
    assign s_axi_rdata_o = r_reg.rdata;
    assign s_axi_rresp_o = r_reg.rresp;
    assign bus_addr_o = r_reg.addr;
    assign bus_cs_n_o = r_reg.cs_n;
    assign bus_rd_n_o = r_reg.rd_n;
    assign bus_wr_n_o = r_reg.wr_n;
    assign bus_data_o = r_reg.wdat;
    assign bus_data_oe_o = r_reg.d_oe;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic e_done;
    assign e_done = tick && r_reg.st == PH_E && r_reg.cnt == 6'h00 && r_reg.ctrl[CTRL_RDY_EN];

    AST_START_LOAD: assert property (
        r_reg.st == PH_IDLE && r_next.st == PH_AB |=> r_reg.st == PH_AB
        && r_reg.cnt == {5'h00, $past(r_reg.tim[TIM_AB])})
        else $error("address phase not loaded from timing");
    AST_E_LOAD: assert property (
        r_reg.st != PH_E ##1 r_reg.st == PH_E |-> r_reg.cnt == {1'b0, r_reg.tim[TIM_E_LSB +: 5]})
        else $error("access phase length wrong");
    AST_MANDATORY: assert property (
        r_reg.st == PH_E && r_reg.cnt != 6'h00 |=> r_reg.st == PH_E)
        else $error("access ended during mandatory units");
    AST_NO_HS_END: assert property (
        tick && r_reg.st == PH_E && r_reg.cnt == 6'h00 && !r_reg.ctrl[CTRL_RDY_EN]
        |=> r_reg.st != PH_E)
        else $error("access did not end on duration");
    AST_ASYNC_EXTRA: assert property (
        e_done && r_reg.ctrl[CTRL_ASYNC] && !r_reg.asy_done |=> r_reg.st == PH_E && r_reg.asy_done)
        else $error("async mode missed its extra waitstate");
    AST_RDY_END: assert property (
        e_done && rdy_act && (!r_reg.ctrl[CTRL_ASYNC] || r_reg.asy_done) |=> r_reg.st != PH_E
        && r_reg.rd_n && r_reg.wr_n)
        else $error("active handshake did not end cycle");
    AST_NOT_RDY_WAIT: assert property (
        e_done && !rdy_act && (!r_reg.ctrl[CTRL_ASYNC] || r_reg.asy_done)
        && r_reg.waits != WAITS_MAX |=> r_reg.st == PH_E && r_reg.waits == $past(r_reg.waits) + 8'h01)
        else $error("inactive handshake did not add a waitstate");
    AST_RDATA_EDGE: assert property (
        $rose(r_reg.rd_n) |-> r_reg.rdat == $past(r_reg.d_s2))
        else $error("read data not latched at strobe release");
    AST_STROBE_PHASE: assert property (
        !r_reg.wr_n |-> r_reg.st == PH_E && !r_reg.cs_n && r_reg.rd_n)
        else $error("write strobe outside access phase");

    COV_READ_WAIT: cover property (r_reg.st == PH_E && !r_reg.is_wr && r_reg.waits == 8'h02
        ##1 $rose(r_reg.rd_n));
    COV_WRITE: cover property ($rose(r_reg.wr_n) && r_reg.is_wr);
    COV_ASYNC_END: cover property (e_done && r_reg.ctrl[CTRL_ASYNC] && r_reg.asy_done && rdy_act);
    COV_BUSY_CMD: cover property (r_reg.bvalid && r_reg.bresp == RESP_SLVERR);

endmodule : ebrwc_top

`default_nettype wire

// File: src/ebrwc_pkg.sv
`default_nettype none

package ebrwc_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMING = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RDATA = 8'h14;

    // ****************************************
    // field layout
    // ****************************************
    localparam int CTRL_W = 3;
    localparam int CTRL_RDY_EN = 0;
    localparam int CTRL_RDY_POL = 1;
    localparam int CTRL_ASYNC = 2;
    localparam int TIM_W = 11;
    localparam int TIM_AB = 0;
    localparam int TIM_C_LSB = 1;
    localparam int TIM_D = 3;
    localparam int TIM_E_LSB = 4;
    localparam int TIM_F_LSB = 9;
    localparam int CMD_WRITE = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RDY = 1;
    localparam int STAT_WAITS_LSB = 8;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [TIM_W-1:0] TIM_RST = 11'h000;
    localparam logic [7:0] WAITS_MAX = 8'hff;
    localparam int BUS_AW = 16;
    localparam int BUS_DW = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // bus cycle phases
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_AB = 3'b001,
        PH_C = 3'b010,
        PH_D = 3'b011,
        PH_E = 3'b100,
        PH_F = 3'b101
    } ebrwc_phase_e;

endpackage : ebrwc_pkg

`default_nettype wire

// File: src/ebrwc_tcs_div.sv
`default_nettype none

module ebrwc_unit_div #(
    parameter int DIV = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // timing unit
    output logic tick_o,
    output logic ref_clk_o
);
    import ebrwc_pkg::*;

    localparam int CW = $clog2(DIV + 1);

    if (DIV < 1) begin : g_chk
        $error("ebrwc_unit_div: DIV must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
        logic refclk;
    } ebrwc_div_s;

    ebrwc_div_s div_reg;
    ebrwc_div_s div_next;

    always_comb begin
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (div_reg.cnt == CW'(DIV - 1)) begin
            div_next.cnt = '0;
            div_next.tick = 1'b1;
            div_next.refclk = ~div_reg.refclk;
        end else begin
            div_next.cnt = div_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick_o = div_reg.tick;
    assign ref_clk_o = div_reg.refclk;

endmodule : ebrwc_unit_div

`default_nettype wire

// File: src/ebrwc_rdy_sync.sv
`default_nettype none

module ebrwc_rdy_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // handshake pin and mode
    input wire logic ready_pin_i,
    input wire logic pol_high_i,
    input wire logic async_i,
    // conditioned level
    output logic rdy_active_o
);
    import ebrwc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ebrwc_sync_s;

    ebrwc_sync_s sy_reg;
    ebrwc_sync_s sy_next;

    always_comb begin
        sy_next.s1 = ready_pin_i;
        sy_next.s2 = sy_reg.s1;
        sy_next.s3 = sy_reg.s2;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sy_reg <= '0;
        end else begin
            sy_reg <= sy_next;
        end
    end

    // sync mode takes the sampled level, async adds a stage
    // polarity select
    assign rdy_active_o = (async_i ? sy_reg.s3 : sy_reg.s2) ~^ pol_high_i;

    // ****************************************
    // checks
    // ****************************************
    AST_ASYNC_STAGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        async_i && $stable(pol_high_i) |-> rdy_active_o == ($past(sy_reg.s2) ~^ pol_high_i))
        else $error("async path is not one stage behind");

    AST_POLARITY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !async_i && sy_reg.s2 |-> rdy_active_o == pol_high_i)
        else $error("ready polarity select wrong");

endmodule : ebrwc_rdy_sync

`default_nettype wire

// File: testbench/ebrwc_mem_model.sv
`default_nettype none

module ebrwc_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bus pins seen from the memory
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic ready_o,
    output logic [15:0] data_o,
    // behaviour set by the bench
    input wire logic pol_high_i,
    input wire logic [7:0] delay_i,
    input wire logic [15:0] word_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;
    logic act;

    // ****************************************
    // handshake
    // ****************************************
    // only changes on clk_i edges, so it follows the controller clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 8'h00;
            act <= 1'b0;
        end else if (cs_n_i || (rd_n_i && wr_n_i)) begin
            // dropped at the first clk_i edge after the strobe trailing edge, well before the next sample
            cnt <= 8'h00;
            act <= 1'b0;
        end else if (cnt >= delay_i && delay_i != 8'hff) begin
            // held until the strobe ends: longer than a period plus setup
            act <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    assign ready_o = act ~^ pol_high_i;
    // a released bus shows the inverse, so a stale word never matches
    assign data_o = (!cs_n_i && !rd_n_i) ? word_i : ~word_i;

endmodule : ebrwc_mem_model

`default_nettype wire

// File: testbench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebrwc_pkg::*;

    logic clk_i, rst_n_i;
    logic [7:0] awaddr, araddr, delay;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] bus_addr, bus_do, bus_di, word, wr_seen;
    logic cs_n, rd_n, wr_n, oe, ready, refclk, pol;
    int fails, total_checks, cs_cnt, st_cnt;

    ebrwc_top #(.AW(8), .UNIT_DIV(1)) ebrwc_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_addr_o(bus_addr),
        .bus_cs_n_o(cs_n), .bus_rd_n_o(rd_n), .bus_wr_n_o(wr_n), .bus_data_o(bus_do),
        .bus_data_oe_o(oe), .bus_data_i(bus_di), .bus_ready_i(ready),
        .reference_clock_output_o(refclk));

    ebrwc_mem_model ebrwc_mem_model_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .ready_o(ready), .data_o(bus_di), .pol_high_i(pol), .delay_i(delay), .word_i(word));

    // ****************************************
    // bus monitor and reporting
    // ****************************************
    always @(posedge clk_i) begin
        if (!cs_n) cs_cnt <= cs_cnt + 1;
        if (!(rd_n && wr_n)) st_cnt <= st_cnt + 1;
        if (!wr_n && oe) wr_seen <= bus_do;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic give_up;
        fails++;
        report_and_stop();
    endtask : give_up

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // ****************************************
    // register bus master
    // ****************************************
    // handshakes judged at the falling edge, acted on at the next rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        int n;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk_i);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = bresp;
            @(posedge clk_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) break;
        end
        bready <= 1'b0;
        if (n == 100) give_up();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        int n;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk_i);
            ar_t = arvalid && arready;
            r_t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_i);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) break;
        end
        rready <= 1'b0;
        if (n == 100) give_up();
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(what, exp, d);
        check("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rd_chk

    task automatic setup(input logic [2:0] c, input logic p, input logic [7:0] dl);
        logic [1:0] r;
        pol <= p;
        delay <= dl;
        axi_wr(OFS_CTRL, {29'h0, c}, r);
    endtask : setup

    task automatic wait_end;
        int n;
        for (n = 0; n < 600 && !(cs_cnt > 0 && cs_n); n++) @(negedge clk_i);
        if (n == 600) give_up();
    endtask : wait_end

    task automatic run_cycle(input logic wr, input logic [15:0] a, output logic [31:0] st);
        logic [1:0] r;
        cs_cnt = 0;
        st_cnt = 0;
        axi_wr(OFS_CMD, {15'h0, wr, a}, r);
        check("cmd resp", {30'h0, RESP_OKAY}, {30'h0, r});
        wait_end();
        axi_rd(OFS_STATUS, st, r);
    endtask : run_cycle

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_regs;
        logic [31:0] d;
        logic [1:0] r;
        logic p;
        @(negedge clk_i);
        p = refclk;
        @(negedge clk_i);
        check("refclk toggles", {31'h0, ~p}, {31'h0, refclk});
        check("oe idle", 32'h0, {31'h0, oe});
        rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
        rd_chk(OFS_TIMING, 32'h0, "timing reset");
        check("cs idle", 32'h1, {31'h0, cs_n});
        axi_wr(OFS_CTRL, 32'h7, r);
        rd_chk(OFS_CTRL, 32'h7, "ctrl rw");
        axi_wr(OFS_STATUS, 32'hffff_ffff, r);
        check("ro bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_rd(8'h18, d, r);
        check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        check("unmapped rdata", 32'h0, d);
        axi_wr(8'h1c, 32'h1, r);
        check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask : s_regs

    // AB 2, C 2, D 1, E 3, F 1 units, handshake off
    task automatic s_fixed;
        logic [31:0] st;
        logic [1:0] r;
        setup(3'h0, 1'b1, 8'hff);
        axi_wr(OFS_TIMING, 32'h22d, r);
        word <= 16'h5a3c;
        run_cycle(1'b0, 16'h1234, st);
        check("cs len", 32'd9, cs_cnt);
        check("rd len", 32'd4, st_cnt);
        check("bus addr", 32'h1234, {16'h0, bus_addr});
        rd_chk(OFS_RDATA, 32'h5a3c, "rdata");
        axi_wr(OFS_WDATA, 32'hc3a5, r);
        delay <= 8'h00;
        run_cycle(1'b1, 16'h0042, st);
        check("wr len", 32'd3, st_cnt);
        check("wr data", 32'hc3a5, {16'h0, wr_seen});
    endtask : s_fixed

    task automatic s_busy;
        logic [1:0] r;
        cs_cnt = 0;
        axi_wr(OFS_CMD, 32'h0, r);
        axi_wr(OFS_CMD, 32'h1_0000, r);
        check("cmd busy", {30'h0, RESP_SLVERR}, {30'h0, r});
        wait_end();
        check("one cycle only", 32'd9, cs_cnt);
    endtask : s_busy

    // prompt partner in all four polarity and sync modes
    task automatic s_modes;
        logic [31:0] st;
        for (int m = 0; m < 4; m++) begin
            setup({m[1], m[0], 1'b1}, m[0], 8'h00);
            run_cycle(1'b0, 16'h0010, st);
            check("waits", {31'h0, m[1]}, {24'h0, st[15:8]});
            check("not busy", 32'h0, {31'h0, st[0]});
            check("rd len", 32'd4 + {31'h0, m[1]}, st_cnt);
        end
    endtask : s_modes

    // slow partner, then a partner of the wrong polarity
    task automatic s_slow;
        logic [31:0] st;
        for (int k = 0; k < 2; k++) begin
            setup({k[0], 2'b11}, 1'b1, 8'h08);
            run_cycle(1'b0, 16'h0020, st);
            check("stretched", 32'h1, {31'h0, st_cnt > 9});
            check("len by waits", 32'd4 + {24'h0, st[15:8]}, st_cnt);
        end
        setup(3'h3, 1'b0, 8'hff);
        run_cycle(1'b0, 16'h0030, st);
        check("inverted ready", 32'd4, st_cnt);
    endtask : s_slow

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_n_i = 1'b0;
        {awaddr, araddr, wdata, word} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        pol = 1'b1;
        delay = 8'hff;
        fails = 0;
        total_checks = 0;
        cs_cnt = 0;
        st_cnt = 0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        s_regs();
        s_fixed();
        s_busy();
        s_modes();
        s_slow();
        report_and_stop();
    end

endmodule : tb

`default_nettype wire
